// ### logic/cscc_core_regs.v
// Purpose: CPU status flags and core configuration registers with flag update logic
// Assumes: ALU and DSP datapath report results and events on ref_clk; one cycle latency
// Notes: Register port is word indexed; reads return data the cycle after the strobe
//        Priority loads from the interrupt controller beat a same-cycle software write
//        Sticky clip bits live in a small cell module at the end of this file
//
// The strobed register port and the register offsets were chosen for this implementation.

`include "cscc_map.vh"

module cscc_core_regs (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  // Register port
  input wire [`CSCC_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // ALU result flags
  input wire alu_flag_we,
  input wire alu_is_sub,
  input wire alu_byte_op,
  input wire [15:0] alu_result,
  input wire alu_carry_out,
  input wire alu_half_carry_out,
  input wire alu_overflow,
  input wire alu_z_update,
  // Accumulator events
  input wire acc_a_ovf_in,
  input wire acc_b_ovf_in,
  input wire acc_a_sat_event,
  input wire acc_b_sat_event,
  // Loop state from execution unit
  input wire do_loop_active_in,
  input wire repeat_active_in,
  input wire [2:0] loop_depth_in,
  // Priority level from interrupt controller
  input wire ipl_hw_we,
  input wire [3:0] ipl_hw_value,
  input wire nesting_disable_bit,
  // Configuration outputs
  output reg dsp_unsigned_multiply,
  output reg early_loop_exit,
  output reg acc_a_clip_enable,
  output reg acc_b_clip_enable,
  output reg store_clip_enable,
  output reg clip_width_select,
  output reg program_window_enable,
  output reg rounding_select,
  output reg integer_multiply_select,
  output reg [3:0] cpu_priority_level,
  output reg user_irq_disable
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg acc_a_overflow;
  reg acc_b_overflow;
  wire acc_a_sticky_clip;
  wire acc_b_sticky_clip;
  reg do_loop_active;
  reg half_carry;
  reg [2:0] cpu_priority_low_bits;
  reg repeat_active;
  reg flag_n;
  reg flag_ov;
  reg flag_z;
  reg flag_c;
  reg cpu_priority_top_bit;
  reg [2:0] loop_nesting_depth;

  wire any_acc_overflow;
  wire any_acc_sticky_clip;
  wire wr_flags;
  wire wr_core;
  wire sticky_a_clr;
  wire sticky_b_clr;
  wire [15:0] flags_view;
  wire [15:0] core_view;
  wire result_is_zero;
  wire result_sign;
  wire wdata_half_carry;
  wire wdata_negative;
  wire wdata_overflow;
  wire wdata_zero;
  wire wdata_carry;
  reg [2:0] prio_low_next;
  reg prio_top_next;
  reg [3:0] prio_level_next;
  reg user_off_next;

  assign wr_flags = reg_wr && (reg_addr == `CSCC_OFF_FLAGS);
  assign wr_core = reg_wr && (reg_addr == `CSCC_OFF_CORE);

  assign any_acc_overflow = acc_a_overflow | acc_b_overflow;
  assign any_acc_sticky_clip = acc_a_sticky_clip | acc_b_sticky_clip;

  // Writing zero to the combined bit clears both sticky bits
  assign sticky_a_clr = wr_flags && (!reg_wdata[`CSCC_SR_SA] ||
                        !reg_wdata[`CSCC_SR_SAB]);
  assign sticky_b_clr = wr_flags && (!reg_wdata[`CSCC_SR_SB] ||
                        !reg_wdata[`CSCC_SR_SAB]);

  // ----------------------------------------
  // Sticky saturation bits
  // ----------------------------------------
  cscc_sticky_bit i_sticky_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set_event(acc_a_sat_event),
    .clear_req(sticky_a_clr),
    .flag_reg(acc_a_sticky_clip)
  );

  cscc_sticky_bit i_sticky_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set_event(acc_b_sat_event),
    .clear_req(sticky_b_clr),
    .flag_reg(acc_b_sticky_clip)
  );

  // ----------------------------------------
  // Result decode
  // ----------------------------------------
  // Byte operations look only at the low byte for sign and zero
  assign result_is_zero = alu_byte_op ? (alu_result[7:0] == 8'h00) :
                          (alu_result == 16'h0000);
  assign result_sign = alu_byte_op ? alu_result[7] : alu_result[15];

  // ----------------------------------------
  // Software write fields of the status word
  // ----------------------------------------
  assign wdata_half_carry = reg_wdata[`CSCC_SR_DC];
  assign wdata_negative = reg_wdata[`CSCC_SR_N];
  assign wdata_overflow = reg_wdata[`CSCC_SR_OV];
  assign wdata_zero = reg_wdata[`CSCC_SR_Z];
  assign wdata_carry = reg_wdata[`CSCC_SR_C];

  // ----------------------------------------
  // Priority next state
  // ----------------------------------------
  // Hardware loads beat software so a nested entry is never lost to a write
  always @* begin
    prio_low_next = cpu_priority_low_bits;
    prio_top_next = cpu_priority_top_bit;
    if (ipl_hw_we) begin
      prio_low_next = ipl_hw_value[2:0];
      prio_top_next = ipl_hw_value[3];
    end else begin
      if (wr_flags && !nesting_disable_bit) begin
        prio_low_next = reg_wdata[`CSCC_SR_IPL_HI:`CSCC_SR_IPL_LO];
      end
      // Software may only clear the top bit
      if (wr_core && !reg_wdata[`CSCC_CC_CPU_PRIORITY_TOP_BIT]) begin
        prio_top_next = 1'b0;
      end
    end
    prio_level_next = {cpu_priority_top_bit, cpu_priority_low_bits};
    user_off_next = cpu_priority_top_bit ||
                    (cpu_priority_low_bits == `CSCC_IPL_USER_OFF);
  end

  // ----------------------------------------
  // Read views
  // ----------------------------------------
  assign flags_view[`CSCC_SR_OA] = acc_a_overflow;
  assign flags_view[`CSCC_SR_OB] = acc_b_overflow;
  assign flags_view[`CSCC_SR_SA] = acc_a_sticky_clip;
  assign flags_view[`CSCC_SR_SB] = acc_b_sticky_clip;
  assign flags_view[`CSCC_SR_OAB] = any_acc_overflow;
  assign flags_view[`CSCC_SR_SAB] = any_acc_sticky_clip;
  assign flags_view[`CSCC_SR_DA] = do_loop_active;
  assign flags_view[`CSCC_SR_DC] = half_carry;
  assign flags_view[`CSCC_SR_IPL_HI:`CSCC_SR_IPL_LO] = cpu_priority_low_bits;
  assign flags_view[`CSCC_SR_RA] = repeat_active;
  assign flags_view[`CSCC_SR_N] = flag_n;
  assign flags_view[`CSCC_SR_OV] = flag_ov;
  assign flags_view[`CSCC_SR_Z] = flag_z;
  assign flags_view[`CSCC_SR_C] = flag_c;
  // Unimplemented top bits and the early exit bit read as zero
  assign core_view[15:13] = 3'b000;
  assign core_view[`CSCC_CC_US] = dsp_unsigned_multiply;
  assign core_view[`CSCC_CC_EDT] = 1'b0;
  assign core_view[`CSCC_CC_DL_HI:`CSCC_CC_DL_LO] = loop_nesting_depth;
  assign core_view[`CSCC_CC_ACC_A_CLIP_ENABLE] = acc_a_clip_enable;
  assign core_view[`CSCC_CC_ACC_B_CLIP_ENABLE] = acc_b_clip_enable;
  assign core_view[`CSCC_CC_STORE_CLIP_ENABLE] = store_clip_enable;
  assign core_view[`CSCC_CC_CLIP_WIDTH_SELECT] = clip_width_select;
  assign core_view[`CSCC_CC_CPU_PRIORITY_TOP_BIT] = cpu_priority_top_bit;
  assign core_view[`CSCC_CC_PSV] = program_window_enable;
  assign core_view[`CSCC_CC_RND] = rounding_select;
  assign core_view[`CSCC_CC_IF] = integer_multiply_select;

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_a_overflow <= 1'b0;
      acc_b_overflow <= 1'b0;
      do_loop_active <= 1'b0;
      half_carry <= 1'b0;
      cpu_priority_low_bits <= 3'h0;
      repeat_active <= 1'b0;
      flag_n <= 1'b0;
      flag_ov <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
    end else if (clk_en) begin
      acc_a_overflow <= acc_a_ovf_in;
      acc_b_overflow <= acc_b_ovf_in;
      do_loop_active <= do_loop_active_in;
      repeat_active <= repeat_active_in;
      // Software write of the writable ALU flags; ALU update below takes priority
      if (wr_flags) begin
        half_carry <= wdata_half_carry;
        flag_n <= wdata_negative;
        flag_ov <= wdata_overflow;
        flag_z <= wdata_zero;
        flag_c <= wdata_carry;
      end
      cpu_priority_low_bits <= prio_low_next;
      if (alu_flag_we) begin
        // Datapath supplies inverted carries on subtract, so one means no borrow
        flag_c <= alu_carry_out;
        half_carry <= alu_half_carry_out;
        flag_ov <= alu_overflow;
        flag_n <= result_sign;
        // Zero is only cleared by a non-zero result; sticky-set form for chained ops
        if (!result_is_zero)
          flag_z <= 1'b0;
        else if (alu_z_update)
          flag_z <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Core configuration register
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_unsigned_multiply <= 1'b0;
      early_loop_exit <= 1'b0;
      acc_a_clip_enable <= 1'b0;
      acc_b_clip_enable <= 1'b0;
      store_clip_enable <= 1'b1;
      clip_width_select <= 1'b0;
      cpu_priority_top_bit <= 1'b0;
      program_window_enable <= 1'b0;
      rounding_select <= 1'b0;
      integer_multiply_select <= 1'b0;
      loop_nesting_depth <= 3'h0;
    end else if (clk_en) begin
      loop_nesting_depth <= loop_depth_in;
      // Early exit is a one-cycle request to the loop controller
      early_loop_exit <= wr_core && reg_wdata[`CSCC_CC_EDT];
      if (wr_core) begin
        dsp_unsigned_multiply <= reg_wdata[`CSCC_CC_US];
        acc_a_clip_enable <= reg_wdata[`CSCC_CC_ACC_A_CLIP_ENABLE];
        acc_b_clip_enable <= reg_wdata[`CSCC_CC_ACC_B_CLIP_ENABLE];
        store_clip_enable <= reg_wdata[`CSCC_CC_STORE_CLIP_ENABLE];
        clip_width_select <= reg_wdata[`CSCC_CC_CLIP_WIDTH_SELECT];
        program_window_enable <= reg_wdata[`CSCC_CC_PSV];
        rounding_select <= reg_wdata[`CSCC_CC_RND];
        integer_multiply_select <= reg_wdata[`CSCC_CC_IF];
      end
      // Top priority bit is set by the interrupt controller; software may only clear it
      cpu_priority_top_bit <= prio_top_next;
    end
  end

  // ----------------------------------------
  // Priority outputs and read port
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_priority_level <= 4'h0;
      user_irq_disable <= 1'b0;
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      cpu_priority_level <= prio_level_next;
      user_irq_disable <= user_off_next;
      if (reg_rd) begin
        case (reg_addr)
          `CSCC_OFF_FLAGS: reg_rdata <= flags_view;
          `CSCC_OFF_CORE: reg_rdata <= core_view;
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

endmodule // cscc_core_regs

// ----------------------------------------
// Sticky flag cell
// ----------------------------------------
// A hardware event sets the flag and software may only clear it.
// Set wins over a same-cycle clear so no saturation is ever missed.
module cscc_sticky_bit (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  // Set and clear requests
  input wire set_event,
  input wire clear_req,
  // Flag
  output reg flag_reg
);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (set_event) begin
        flag_reg <= 1'b1;
      end else if (clear_req) begin
        flag_reg <= 1'b0;
      end
    end
  end

endmodule // cscc_sticky_bit

// ### shared/cscc_map.vh
// Purpose: Offsets, field positions, reset values of the status/config bank
// Assumes: 16-bit registers, word-indexed plain register port
// Notes: Definitions only
`ifndef CSCC_MAP_VH
`define CSCC_MAP_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CSCC_ADDR_W 4
`define CSCC_OFF_FLAGS 4'h0
`define CSCC_OFF_CORE 4'h1

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define CSCC_SR_OA 15
`define CSCC_SR_OB 14
`define CSCC_SR_SA 13
`define CSCC_SR_SB 12
`define CSCC_SR_OAB 11
`define CSCC_SR_SAB 10
`define CSCC_SR_DA 9
`define CSCC_SR_DC 8
`define CSCC_SR_IPL_HI 7
`define CSCC_SR_IPL_LO 5
`define CSCC_SR_RA 4
`define CSCC_SR_N 3
`define CSCC_SR_OV 2
`define CSCC_SR_Z 1
`define CSCC_SR_C 0

// ----------------------------------------
// Core configuration fields
// ----------------------------------------
`define CSCC_CC_US 12
`define CSCC_CC_EDT 11
`define CSCC_CC_DL_HI 10
`define CSCC_CC_DL_LO 8
`define CSCC_CC_ACC_A_CLIP_ENABLE 7
`define CSCC_CC_ACC_B_CLIP_ENABLE 6
`define CSCC_CC_STORE_CLIP_ENABLE 5
`define CSCC_CC_CLIP_WIDTH_SELECT 4
`define CSCC_CC_CPU_PRIORITY_TOP_BIT 3
`define CSCC_CC_PSV 2
`define CSCC_CC_RND 1
`define CSCC_CC_IF 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSCC_SR_RESET 16'h0000
`define CSCC_CC_RESET 16'h0020
`define CSCC_IPL_USER_OFF 3'h7

`endif

// ### tb/cpu_status_core_config_test.sv
// Purpose: Register-level checks of the status and core config bank
// Assumes: 40 MHz ref_clk, clk_en high except during the frozen config write
// Notes: Datapath events come from the execution model
module cpu_status_core_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic nesting_disable_bit = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, alu_result;
  logic alu_flag_we, alu_is_sub, alu_byte_op, alu_carry_out, alu_half_carry_out;
  logic alu_overflow, alu_z_update, acc_a_ovf_in, acc_b_ovf_in, acc_a_sat_event;
  logic acc_b_sat_event, do_loop_active_in, repeat_active_in, ipl_hw_we, user_irq_disable;
  logic [2:0] loop_depth_in;
  logic [3:0] ipl_hw_value, cpu_priority_level;
  logic dsp_unsigned_multiply, early_loop_exit, acc_a_clip_enable, acc_b_clip_enable;
  logic store_clip_enable, clip_width_select, program_window_enable, rounding_select;
  logic integer_multiply_select;
  int fails = 0, checks = 0, cycles = 0;
  // Result, {sub, byte, carry, half carry, overflow, z update}, low status
  localparam logic [37:0] alu_tab [5] = '{{16'h8000, 6'h0B, 16'h000D},
    {16'h0000, 6'h01, 16'h0002}, {16'h0000, 6'h00, 16'h0002},
    {16'h0012, 6'h14, 16'h0100}, {16'h0001, 6'h2C, 16'h0101}};
  cscc_core_regs i_cscc_core_regs (.*);
  cscc_exec_model i_cscc_exec_model (.*);
  always #12.5 ref_clk = ~ref_clk;
  // Whole run needs under a hundred cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rcmp(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(n, e, reg_rdata);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rcmp("status", 4'h0, 16'h0000);
    rcmp("config", 4'h1, 16'h0020);
    i_cscc_exec_model.lvl(7'h1D);
    wr(4'h1, 16'hFFFF);
    rcmp("config", 4'h1, 16'h15F7);
    cmp("cfg pins", 16'h00FF, {8'h00, dsp_unsigned_multiply, acc_a_clip_enable, acc_b_clip_enable, store_clip_enable, clip_width_select, program_window_enable, rounding_select, integer_multiply_select});
    wr(4'h0, 16'hFFFF);
    rcmp("status", 4'h0, 16'h03FF);
    cmp("prio", 16'h0017, {11'h000, user_irq_disable, cpu_priority_level});
    @(posedge ref_clk) nesting_disable_bit <= 1'b1;
    wr(4'h0, 16'h0000);
    rcmp("status", 4'h0, 16'h02F0);
    @(posedge ref_clk) nesting_disable_bit <= 1'b0;
    i_cscc_exec_model.lvl(7'h00);
    i_cscc_exec_model.ipl(4'hA);
    rcmp("config", 4'h1, 16'h10FF);
    cmp("prio", 16'h001A, {11'h000, user_irq_disable, cpu_priority_level});
    wr(4'h1, 16'h0000);
    rcmp("config", 4'h1, 16'h0000);
    cmp("prio", 16'h0002, {11'h000, user_irq_disable, cpu_priority_level});
    cmp("cfg pins", 16'h0000, {8'h00, dsp_unsigned_multiply, acc_a_clip_enable, acc_b_clip_enable, store_clip_enable, clip_width_select, program_window_enable, rounding_select, integer_multiply_select});
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(4'h1, 16'h00FF);
    @(posedge ref_clk) clk_en <= 1'b1;
    rcmp("frozen config", 4'h1, 16'h0000);
    wr(4'h0, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      i_cscc_exec_model.alu(alu_tab[i][37:22], alu_tab[i][21:16]);
      rcmp("alu flags", 4'h0, alu_tab[i][15:0]);
    end
    i_cscc_exec_model.lvl(7'h40);
    rcmp("status", 4'h0, 16'h8901);
    i_cscc_exec_model.sat(2'b11);
    i_cscc_exec_model.lvl(7'h00);
    rcmp("status", 4'h0, 16'h3501);
    wr(4'h0, 16'h3101);
    rcmp("status", 4'h0, 16'h0101);
    rcmp("unmapped", 4'h5, 16'h0000);
    end_of_test();
  end
endmodule // cpu_status_core_config_test

// ### tb/cscc_core_regs_chk.sv
// Purpose: Port-level assertions for the status and config bank
// Assumes: One ref_clk domain
// Notes: Status contents are judged by the bench through reads
`include "cscc_map.vh"
module cscc_core_regs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [`CSCC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Priority and configuration
  input wire logic ipl_hw_we,
  input wire logic [3:0] ipl_hw_value,
  input wire logic dsp_unsigned_multiply,
  input wire logic store_clip_enable,
  input wire logic clip_width_select,
  input wire logic early_loop_exit,
  input wire logic [3:0] cpu_priority_level,
  input wire logic user_irq_disable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [2:0] cfg = {dsp_unsigned_multiply, store_clip_enable, clip_width_select};
  a_cfg_write: assert property (clk_en && reg_wr && reg_addr == 4'h1 |=> cfg == $past({reg_wdata[12], reg_wdata[5:4]}))
    else $error("config outputs differ from write");
  a_cfg_hold: assert property (!$past(clk_en && reg_wr && reg_addr == 4'h1) |-> $stable(cfg))
    else $error("config outputs moved without write");
  a_exit_pulse: assert property ($past(clk_en) |-> early_loop_exit == $past(reg_wr && reg_addr == 4'h1 && reg_wdata[11]))
    else $error("early exit pulse wrong");
  a_rd_window: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_rd_unmapped: assert property (clk_en && reg_rd && reg_addr > 4'h1 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rd_core_top: assert property (clk_en && reg_rd && reg_addr == 4'h1 |=> reg_rdata[15:11] == {3'b000, $past(dsp_unsigned_multiply), 1'b0})
    else $error("config upper bits wrong");
  a_ipl_load: assert property (clk_en && ipl_hw_we ##1 clk_en && !(ipl_hw_we || reg_wr) |=> cpu_priority_level == $past(ipl_hw_value, 2))
    else $error("priority load wrong");
  a_user_off: assert property (user_irq_disable == (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
    else $error("user interrupt disable wrong");
  c_exit: cover property (reg_wr && reg_addr == 4'h1 && reg_wdata[11]);
  c_ipl: cover property (ipl_hw_we);
  c_unmapped: cover property (reg_rd && reg_addr > 4'h1);
endmodule // cscc_core_regs_chk
bind cscc_core_regs cscc_core_regs_chk i_cscc_core_regs_chk (.*);

// ### tb/cscc_exec_model.sv
// Purpose: Execution unit and datapath stand-in for the flag bank
// Assumes: Pulses last one ref_clk cycle, launched just after an edge
// Notes: Levels hold until the next call
module cscc_exec_model (
  // Clock
  input wire ref_clk,
  // ALU results
  output logic alu_flag_we,
  output logic alu_is_sub,
  output logic alu_byte_op,
  output logic [15:0] alu_result,
  output logic alu_carry_out,
  output logic alu_half_carry_out,
  output logic alu_overflow,
  output logic alu_z_update,
  // Accumulator, loop and priority state
  output logic acc_a_ovf_in,
  output logic acc_b_ovf_in,
  output logic acc_a_sat_event,
  output logic acc_b_sat_event,
  output logic do_loop_active_in,
  output logic repeat_active_in,
  output logic [2:0] loop_depth_in,
  output logic ipl_hw_we,
  output logic [3:0] ipl_hw_value
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {alu_flag_we, alu_is_sub, alu_byte_op, alu_result, alu_carry_out} = '0;
    {alu_half_carry_out, alu_overflow, alu_z_update, acc_a_sat_event} = '0;
    {acc_b_sat_event, ipl_hw_we, ipl_hw_value} = '0;
    lvl(7'h00);
  end
  // Subtract carries come already in the no-borrow sense
  task automatic alu(input logic [15:0] r, input logic [5:0] f);
    @(posedge ref_clk);
    {alu_is_sub, alu_byte_op, alu_carry_out, alu_half_carry_out, alu_overflow} <= f[5:1];
    alu_z_update <= f[0];
    alu_result <= r;
    alu_flag_we <= 1'b1;
    @(posedge ref_clk);
    alu_flag_we <= 1'b0;
  endtask
  task automatic sat(input logic [1:0] s);
    @(posedge ref_clk);
    {acc_a_sat_event, acc_b_sat_event} <= s;
    @(posedge ref_clk);
    {acc_a_sat_event, acc_b_sat_event} <= 2'b00;
  endtask
  task automatic ipl(input logic [3:0] v);
    @(posedge ref_clk);
    ipl_hw_value <= v;
    ipl_hw_we <= 1'b1;
    @(posedge ref_clk);
    ipl_hw_we <= 1'b0;
  endtask
  task automatic lvl(input logic [6:0] v);
    @(posedge ref_clk);
    {acc_a_ovf_in, acc_b_ovf_in, do_loop_active_in, repeat_active_in, loop_depth_in} <= v;
  endtask
endmodule // cscc_exec_model
